// ---- ppc_pkg.sv ----
// shared constants, descriptor layouts and state codes for the completer
package ppc_pkg;
  localparam int HOLD_W = 256;
  localparam int CPL_W = 128;
  localparam int REGION_BYTES = 2048;
  localparam int TOTAL_BYTES = 8192;
  localparam int REGION_DWORDS = REGION_BYTES / 4;
  localparam int RAM_DWORDS = TOTAL_BYTES / 4;
  localparam int DEF_DATA_W = 256;
  localparam logic [3:0] REQ_MEM_RD = 4'h0;
  localparam logic [3:0] REQ_MEM_WR = 4'h1;
  localparam logic [3:0] REQ_IO_RD = 4'h2;
  localparam logic [3:0] REQ_IO_WR = 4'h3;
  localparam logic [2:0] BAR_MEM32 = 3'h0;
  localparam logic [2:0] BAR_MEM64 = 3'h1;
  localparam logic [2:0] BAR_EROM = 3'h6;
  localparam logic [2:0] DEF_IO_BAR = 3'h2;
  localparam logic [2:0] TRIG_BAR = 3'h0;
  localparam logic [1:0] RGN_IO = 2'h0;
  localparam logic [1:0] RGN_MEM32 = 2'h1;
  localparam logic [1:0] RGN_MEM64 = 2'h2;
  localparam logic [1:0] RGN_EROM = 2'h3;
  localparam logic [11:0] TRIG_RD_ADDR = 12'hea8;
  localparam logic [11:0] TRIG_INT_ADDR = 12'heec;
  localparam logic [31:0] TRIG_RD_DATA = 32'haaaa_bbbb;
  localparam logic [31:0] TRIG_LEG_DATA = 32'hcccc_dddd;
  localparam logic [31:0] TRIG_MSI_DATA = 32'heeee_ffff;
  localparam logic [31:0] TRIG_MSIX_DATA = 32'hdead_beef;
  localparam logic [10:0] ONE_DWORD = 11'h1;
  localparam logic [12:0] CPL_BYTE_COUNT = 13'h4;
  localparam logic [2:0] CPL_STATUS_OK = 3'h0;
  localparam logic [2:0] BEAT_MAX = 3'h7;
  localparam logic [1:0] FIFO_DEPTH = 2'h2;

  typedef struct packed {
    logic rsvd127;
    logic [2:0] attr;
    logic [2:0] tc;
    logic [5:0] aperture;
    logic [2:0] target_region_index;
    logic [7:0] target_func;
    logic [7:0] tag;
    logic [15:0] requester_id;
    logic rsvd79;
    logic [3:0] req_type;
    logic [10:0] dword_count;
    logic [61:0] addr;
    logic [1:0] at;
  } ppc_cq_desc_type;

  typedef struct packed {
    logic rsvd95;
    logic [2:0] attr;
    logic [2:0] tc;
    logic completer_id_en;
    logic [15:0] completer_id;
    logic [7:0] tag;
    logic [15:0] requester_id;
    logic rsvd47;
    logic poisoned;
    logic [2:0] status;
    logic [10:0] dword_count;
    logic rsvd31;
    logic locked;
    logic request_completed;
    logic [12:0] byte_count;
    logic [5:0] rsvd15;
    logic [1:0] at;
    logic rsvd7;
    logic [6:0] lower_addr;
  } ppc_cc_desc_type;

  typedef struct packed {
    logic mem_read;
    logic legacy;
    logic msi;
    logic msix;
  } ppc_trig_type;

  typedef enum logic [2:0] {ST_RECV, ST_DECODE, ST_WRITE, ST_CPL, ST_WAIT} ppc_state_type;
endpackage

// ---- ppc_completer.sv ----
// programmed i/o completer: request collector, region rams, completion path
// Summary of operation
// - four separate 2 KB ram regions, 8192 bytes of target space in total
// - serve single-dword reads and writes to mem32, mem64 and i/o, with completions for reads and i/o writes
// - target region taken from index bits 114:112 of the request descriptor
// - stream width may be 64, 128 or 256 bits with equal behaviour
// - every valid read returns a completion carrying exactly one data dword
// - every valid i/o write returns a successful completion without data
// - write to region index 0 at ea8 with aaaabbbb starts outbound memory read
// - write to region index 0 at eec with ccccdddd raises legacy interrupt
// - write to region index 0 at eec with eeeeffff raises msi
// - write to region index 0 at eec with deadbeef raises msi-x
// - single-dword write payload is stored at addressed location of chosen region
// - index 000b mem32, 001b mem64, 110b expansion rom; i/o off by default
// - one space per type; requests to other indices get no completion
// - only low offset bits used, larger apertures wrap onto the 2 KB
// - single i/o region, disabled by default, enabled by a parameter
// - longer memory requests are taken in full and dropped silently
// - after a read, refuse requests until its completion has been sent
// - after a memory write, refuse requests until write-pending drops; after an i/o write, until its completion has been sent
`timescale 1ns/10ps
module ppc_completer #(
  parameter int DATA_W = ppc_pkg::DEF_DATA_W,
  parameter bit IO_ENABLE = 1'b0,
  parameter logic [2:0] IO_BAR_INDEX = ppc_pkg::DEF_IO_BAR
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [DATA_W-1:0] cq_tdata,
  input wire logic cq_tvalid,
  input wire logic cq_tlast,
  output logic request_stream_accept,
  output logic [DATA_W-1:0] cc_tdata,
  output logic cc_tvalid,
  output logic cc_tlast,
  input wire logic cc_tready,
  input wire logic [15:0] completer_id,
  output ppc_pkg::ppc_trig_type trig,
  output logic compl_done,
  output logic wr_busy
);
  import ppc_pkg::*;

  localparam int CPL_BEATS = (DATA_W >= CPL_W) ? 1 : CPL_W / DATA_W;
  localparam logic [2:0] CPL_LAST_IDX = 3'(CPL_BEATS - 1);

  generate
    if (!(DATA_W == 64 || DATA_W == 128 || DATA_W == 256)) begin : g_width_check
      $error("stream width must be 64, 128 or 256");
    end
  endgenerate

  ppc_state_type state_reg, state_next;
  logic [2:0] beat_reg;
  logic [HOLD_W-1:0] hold_reg;
  logic [31:0] ram [0:RAM_DWORDS-1];
  logic [31:0] rdata_reg;
  logic cpl_data_reg;
  logic [2:0] cpl_idx_reg;
  logic [DATA_W:0] fifo_mem [0:1];
  logic fifo_wr_reg, fifo_rd_reg;
  logic [1:0] fifo_cnt_reg;
  ppc_trig_type trig_reg, trig_next;

  // collector: beats are packed into one holding vector, extra beats fall off
  logic beat_fire;
  logic [HOLD_W-1:0] wide_in, hold_next;
  assign request_stream_accept = ce && (state_reg == ST_RECV);
  assign beat_fire = cq_tvalid && request_stream_accept;
  assign wide_in = HOLD_W'(cq_tdata);
  assign hold_next = ((beat_reg == 3'h0) ? '0 : hold_reg)
                   | (wide_in << (32'(beat_reg) * DATA_W));

  ppc_cq_desc_type desc;
  logic [31:0] payload;
  assign desc = ppc_cq_desc_type'(hold_reg[127:0]);
  assign payload = hold_reg[159:128];

  logic is_rd, is_wr, is_io, idx_mem, io_hit, region_ok, req_ok;
  logic [1:0] region_sel;
  assign is_rd = (desc.req_type == REQ_MEM_RD) || (desc.req_type == REQ_IO_RD);
  assign is_wr = (desc.req_type == REQ_MEM_WR) || (desc.req_type == REQ_IO_WR);
  assign is_io = (desc.req_type == REQ_IO_RD) || (desc.req_type == REQ_IO_WR);
  assign io_hit = IO_ENABLE && (desc.target_region_index == IO_BAR_INDEX);
  assign idx_mem = (desc.target_region_index == BAR_MEM32)
                || (desc.target_region_index == BAR_MEM64)
                || (desc.target_region_index == BAR_EROM);
  assign region_sel = is_io ? RGN_IO
                    : (desc.target_region_index == BAR_MEM32) ? RGN_MEM32
                    : (desc.target_region_index == BAR_MEM64) ? RGN_MEM64 : RGN_EROM;
  assign region_ok = is_io ? io_hit : idx_mem;
  assign req_ok = (is_rd || is_wr) && region_ok && (desc.dword_count == ONE_DWORD);

  logic [10:0] ram_idx;
  assign ram_idx = {region_sel, desc.addr[8:0]};
  logic [11:0] byte_off;
  assign byte_off = {desc.addr[9:0], 2'b00};

  logic in_decode, commit_wr, start_rd;
  assign in_decode = ce && (state_reg == ST_DECODE);
  assign commit_wr = in_decode && req_ok && is_wr;
  assign start_rd = in_decode && req_ok && is_rd;

  logic trig_bar, hit_rd, hit_leg, hit_msi, hit_msix;
  assign trig_bar = commit_wr && (desc.target_region_index == TRIG_BAR);
  assign hit_rd = trig_bar && (byte_off == TRIG_RD_ADDR) && (payload == TRIG_RD_DATA);
  assign hit_leg = trig_bar && (byte_off == TRIG_INT_ADDR) && (payload == TRIG_LEG_DATA);
  assign hit_msi = trig_bar && (byte_off == TRIG_INT_ADDR) && (payload == TRIG_MSI_DATA);
  assign hit_msix = trig_bar && (byte_off == TRIG_INT_ADDR) && (payload == TRIG_MSIX_DATA);
  assign trig_next = '{mem_read: hit_rd, legacy: hit_leg, msi: hit_msi, msix: hit_msix};

  ppc_cc_desc_type cc;
  assign cc = '{rsvd95: 1'b0, attr: desc.attr, tc: desc.tc, completer_id_en: 1'b0,
                completer_id: completer_id, tag: desc.tag,
                requester_id: desc.requester_id, rsvd47: 1'b0, poisoned: 1'b0,
                status: CPL_STATUS_OK,
                dword_count: cpl_data_reg ? ONE_DWORD : 11'h0,
                rsvd31: 1'b0, locked: 1'b0, request_completed: 1'b0,
                byte_count: CPL_BYTE_COUNT, rsvd15: 6'h0, at: desc.at, rsvd7: 1'b0,
                lower_addr: is_io ? 7'h0 : {desc.addr[4:0], 2'b00}};

  logic [HOLD_W-1:0] cpl_wide, cpl_shift;
  logic [DATA_W-1:0] cpl_beat;
  logic cpl_last;
  assign cpl_wide = HOLD_W'({rdata_reg, cc});
  assign cpl_shift = cpl_wide >> (32'(cpl_idx_reg) * DATA_W);
  assign cpl_beat = cpl_shift[DATA_W-1:0];
  assign cpl_last = (cpl_idx_reg == CPL_LAST_IDX);

  // two-entry buffer: a stalled receiver backs up into the serializer
  logic fifo_room, push, pop;
  assign fifo_room = (fifo_cnt_reg != FIFO_DEPTH);
  assign push = ce && (state_reg == ST_CPL) && fifo_room;
  assign cc_tvalid = ce && (fifo_cnt_reg != 2'h0);
  assign pop = cc_tvalid && cc_tready;
  assign cc_tdata = fifo_mem[fifo_rd_reg][DATA_W-1:0];
  assign cc_tlast = fifo_mem[fifo_rd_reg][DATA_W];
  assign compl_done = pop && cc_tlast;
  assign wr_busy = (state_reg == ST_WRITE);
  assign trig = trig_reg;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_RECV: begin
        if (beat_fire && cq_tlast) begin
          state_next = ST_DECODE;
        end
      end
      ST_DECODE: begin
        if (start_rd) begin
          state_next = ST_CPL;
        end else if (commit_wr) begin
          state_next = ST_WRITE;
        end else begin
          state_next = ST_RECV;
        end
      end
      ST_WRITE: begin
        state_next = is_io ? ST_CPL : ST_RECV;
      end
      ST_CPL: begin
        if (push && cpl_last) begin
          state_next = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (compl_done) begin
          state_next = ST_RECV;
        end
      end
      default: state_next = ST_RECV;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_RECV;
      beat_reg <= 3'h0;
      hold_reg <= '0;
      trig_reg <= '0;
    end else if (ce) begin
      state_reg <= state_next;
      trig_reg <= trig_next;
      if (beat_fire) begin
        hold_reg <= hold_next;
        beat_reg <= cq_tlast ? 3'h0 : ((beat_reg == BEAT_MAX) ? beat_reg : beat_reg + 3'h1);
      end
    end
  end

  // region rams, no reset on purpose so they map to block ram
  always_ff @(posedge ref_clk) begin
    if (ce) begin
      if (commit_wr) begin
        ram[ram_idx] <= payload;
      end
      rdata_reg <= ram[ram_idx];
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cpl_data_reg <= 1'b0;
      cpl_idx_reg <= 3'h0;
    end else if (ce) begin
      if (state_reg == ST_DECODE) begin
        cpl_data_reg <= is_rd;
        cpl_idx_reg <= 3'h0;
      end else if (push) begin
        cpl_idx_reg <= cpl_last ? 3'h0 : cpl_idx_reg + 3'h1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      fifo_wr_reg <= 1'b0;
      fifo_rd_reg <= 1'b0;
      fifo_cnt_reg <= 2'h0;
      fifo_mem[0] <= '0;
      fifo_mem[1] <= '0;
    end else if (ce) begin
      if (push) begin
        fifo_mem[fifo_wr_reg] <= {cpl_last, cpl_beat};
        fifo_wr_reg <= ~fifo_wr_reg;
      end
      if (pop) begin
        fifo_rd_reg <= ~fifo_rd_reg;
      end
      fifo_cnt_reg <= fifo_cnt_reg + 2'(push) - 2'(pop);
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn || !ce);

  logic rd_pending;
  assign rd_pending = (state_reg == ST_CPL) || (state_reg == ST_WAIT);

  last_beat_stall_a: assert property ((beat_fire && cq_tlast) |=> !request_stream_accept)
    else $error("request taken right after last beat");
  read_cpl_a: assert property (start_rd |-> ##[2:8] cc_tvalid)
    else $error("read completion not started in time");
  read_block_a: assert property (rd_pending |-> !request_stream_accept)
    else $error("request taken while completion outstanding");
  write_block_a: assert property (wr_busy |-> !request_stream_accept)
    else $error("request taken while write pending");
  drop_long_a: assert property ((in_decode && (desc.dword_count != ONE_DWORD))
                               |=> (state_reg == ST_RECV) && !cc_tvalid)
    else $error("long request not dropped");
  trig_read_a: assert property (hit_rd |=> trig.mem_read && !trig.legacy)
    else $error("outbound read trigger missed");
  trig_legacy_a: assert property (hit_leg |=> trig.legacy && !trig.msi)
    else $error("legacy interrupt trigger missed");
  trig_msi_a: assert property (hit_msi |=> trig.msi && !trig.msix)
    else $error("msi trigger missed");
  trig_msix_a: assert property (hit_msix |=> trig.msix && !trig.mem_read)
    else $error("msi-x trigger missed");
  no_cpl_a: assert property ((in_decode && !region_ok) |=> state_reg == ST_RECV)
    else $error("request to inactive region answered");
  io_wr_cpl_a: assert property ((commit_wr && is_io) |=> ##1 (state_reg == ST_CPL)
                                && !cpl_data_reg)
    else $error("i/o write completion missing");
  busy_single_a: assert property (wr_busy |=> !wr_busy)
    else $error("write pending held too long");
  read_release_a: assert property (compl_done |=> request_stream_accept)
    else $error("request stream not reopened after completion");
  // i/o off unless enabled and matched
  io_off_a: assert property ((in_decode && is_io && !io_hit) |=> state_reg == ST_RECV)
    else $error("i/o request to disabled region served");

  read_done_c: cover property (start_rd ##[1:20] compl_done);
  io_write_c: cover property ((commit_wr && is_io) ##[1:20] compl_done);
  msi_c: cover property (hit_msi);
  dropped_c: cover property (in_decode && (desc.dword_count != ONE_DWORD));
  stall_c: cover property (cc_tvalid && !cc_tready && (fifo_cnt_reg == FIFO_DEPTH));
endmodule

// ---- ppc_core_model.sv ----
// endpoint core model: request source and paced completion sink
`timescale 1ns/10ps
module ppc_core_model (
  input wire logic ref_clk,
  input wire logic request_stream_accept,
  input wire logic [255:0] cc_tdata,
  input wire logic cc_tvalid,
  input wire logic slow,
  output logic [255:0] cq_tdata,
  output logic cq_tvalid,
  output logic cq_tlast,
  output logic cc_tready
);
  import ppc_pkg::*;
  logic [127:0] cpl_q[$];
  logic [1:0] pace = 2'h0;
  initial begin
    cq_tdata = 256'h0;
    cq_tvalid = 1'b0;
    cq_tlast = 1'b0;
    cc_tready = 1'b1;
  end
  // slow mode takes one beat in four, so completions sit in the buffer
  always @(negedge ref_clk) begin
    pace <= pace + 2'h1;
    cc_tready <= !slow || (pace == 2'h3);
  end
  always @(posedge ref_clk) begin
    if (cc_tvalid && cc_tready) begin
      cpl_q.push_back(cc_tdata[127:0]);
    end
  end
  task automatic send(input logic [3:0] kind, input logic [2:0] idx, input logic [61:0] addr,
      input logic [10:0] dw, input logic [7:0] tag, input logic [31:0] data);
    ppc_cq_desc_type d;
    d = '0;
    d.req_type = kind;
    d.target_region_index = idx;
    d.addr = addr;
    d.dword_count = dw;
    d.tag = tag;
    d.requester_id = {8'h01, tag};
    d.attr = 3'h2;
    d.tc = 3'h1;
    @(negedge ref_clk);
    cq_tdata <= {96'h0, data, d};
    cq_tvalid <= 1'b1;
    cq_tlast <= 1'b1;
    while (request_stream_accept !== 1'b1) @(negedge ref_clk);
    @(posedge ref_clk);
    @(negedge ref_clk);
    cq_tvalid <= 1'b0;
    cq_tlast <= 1'b0;
    // released data shows garbage, never the last word
    cq_tdata <= ~cq_tdata;
  endtask
endmodule

// ---- pcie_pio_completer_tb_top.sv ----
// self-checking bench for the programmed i/o completer
`timescale 1ns/10ps
module pcie_pio_completer_tb_top;
  import ppc_pkg::*;
  logic ref_clk, rstn, ce, slow, cq_tvalid, cq_tlast, cc_tvalid, cc_tlast, cc_tready;
  logic accept, compl_done, wr_busy;
  logic [255:0] cq_tdata, cc_tdata;
  ppc_trig_type trig;
  int n_errors, checked;
  int n_cpl, n_last, n_done;

  ppc_completer #(.DATA_W(256), .IO_ENABLE(1'b1), .IO_BAR_INDEX(3'h2)) DUT (
    .ref_clk(ref_clk), .rstn(rstn), .ce(ce), .cq_tdata(cq_tdata), .cq_tvalid(cq_tvalid),
    .cq_tlast(cq_tlast), .request_stream_accept(accept), .cc_tdata(cc_tdata),
    .cc_tvalid(cc_tvalid), .cc_tlast(cc_tlast), .cc_tready(cc_tready),
    .completer_id(16'h0a5c), .trig(trig), .compl_done(compl_done), .wr_busy(wr_busy));
  ppc_core_model u_core (
    .ref_clk(ref_clk), .request_stream_accept(accept), .cc_tdata(cc_tdata),
    .cc_tvalid(cc_tvalid), .slow(slow), .cq_tdata(cq_tdata), .cq_tvalid(cq_tvalid),
    .cq_tlast(cq_tlast), .cc_tready(cc_tready));

  // last beats and done pulses, so cc_tlast and compl_done are judged per completion
  always @(posedge ref_clk) begin
    if (cc_tvalid && cc_tready && cc_tlast) n_last++;
    if (compl_done) n_done++;
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic expect_cpl(input logic [7:0] tag, input logic [61:0] addr,
      input logic [31:0] data, input bit io, input bit nodata);
    ppc_cc_desc_type c;
    logic [127:0] w;
    logic [31:0] got;
    int n;
    n = 0;
    while (u_core.cpl_q.size() == 0 && n < 64) begin
      @(negedge ref_clk);
      n++;
    end
    check("completion", 32'h1, u_core.cpl_q.size() > 0 ? 32'h1 : 32'h0);
    if (u_core.cpl_q.size() > 0) begin
      w = u_core.cpl_q.pop_front();
      c = w[95:0];
      n_cpl++;
      check("last beats", n_cpl, n_last);
      check("done pulses", n_cpl, n_done);
      got = {2'h0, c.tag, c.requester_id, c.attr, c.tc};
      check("ids", {2'h0, tag, 8'h01, tag, 6'h11}, got);
      got = {18'h0, c.dword_count, c.status};
      check("count status", {18'h0, nodata ? 11'h0 : 11'h1, 3'h0}, got);
      got = {12'h0, c.byte_count, c.lower_addr};
      check("bytes low addr", {12'h0, 13'h4, io ? 7'h0 : {addr[4:0], 2'h0}}, got);
      check("completer id", {16'h0, 16'h0a5c}, {16'h0, c.completer_id});
      if (!nodata) check("read data", data, w[127:96]);
    end
  endtask

  task automatic t_regions();
    logic [2:0] idx [4] = '{BAR_MEM32, BAR_MEM64, BAR_EROM, 3'h2};
    for (int i = 0; i < 4; i++) begin
      u_core.send(i == 3 ? REQ_IO_WR : REQ_MEM_WR, idx[i], 62'h7, 11'h1, 8'h13,
                  32'hc0de_0000 + 32'(i));
      if (i == 3) expect_cpl(8'h13, 62'h7, 32'h0, 1'b1, 1'b1);
    end
    // distinct values per region show four separate memories
    for (int i = 0; i < 4; i++) begin
      u_core.send(i == 3 ? REQ_IO_RD : REQ_MEM_RD, idx[i], 62'h7, 11'h1, 8'h20 + 8'(i), 32'h0);
      expect_cpl(8'h20 + 8'(i), 62'h7, 32'hc0de_0000 + 32'(i), i == 3, 1'b0);
    end
    $display("done regions");
  endtask

  task automatic t_wrap();
    u_core.send(REQ_MEM_WR, BAR_MEM64, 62'h9, 11'h1, 8'h30, 32'h5a5a_0009);
    u_core.send(REQ_MEM_RD, BAR_MEM64, 62'h209, 11'h1, 8'h31, 32'h0);
    expect_cpl(8'h31, 62'h209, 32'h5a5a_0009, 1'b0, 1'b0);
    $display("done wrap");
  endtask

  task automatic t_backpressure();
    slow = 1'b1;
    u_core.send(REQ_MEM_RD, BAR_MEM32, 62'h7, 11'h1, 8'h40, 32'h0);
    check("accept while read open", 32'h0, {31'h0, accept});
    u_core.send(REQ_MEM_RD, BAR_MEM64, 62'h9, 11'h1, 8'h41, 32'h0);
    expect_cpl(8'h40, 62'h7, 32'hc0de_0000, 1'b0, 1'b0);
    expect_cpl(8'h41, 62'h9, 32'h5a5a_0009, 1'b0, 1'b0);
    slow = 1'b0;
    $display("done backpressure");
  endtask

  task automatic t_refused();
    u_core.send(REQ_MEM_RD, 3'h3, 62'h7, 11'h1, 8'h50, 32'h0);
    u_core.send(REQ_MEM_RD, BAR_MEM32, 62'h7, 11'h2, 8'h51, 32'h0);
    u_core.send(REQ_IO_RD, BAR_MEM32, 62'h7, 11'h1, 8'h52, 32'h0);
    u_core.send(REQ_MEM_WR, BAR_MEM32, 62'h7, 11'h2, 8'h53, 32'hbad0_0bad);
    repeat (16) @(negedge ref_clk);
    check("dropped completions", 32'h0, u_core.cpl_q.size());
    u_core.send(REQ_MEM_RD, BAR_MEM32, 62'h7, 11'h1, 8'h54, 32'h0);
    expect_cpl(8'h54, 62'h7, 32'hc0de_0000, 1'b0, 1'b0);
    $display("done refused");
  endtask

  task automatic t_triggers();
    logic [61:0] a [5] = '{62'h3aa, 62'h3bb, 62'h3bb, 62'h3bb, 62'h3bb};
    logic [31:0] v [5] = '{TRIG_RD_DATA, TRIG_LEG_DATA, TRIG_MSI_DATA, TRIG_MSIX_DATA,
                           TRIG_MSI_DATA};
    logic [2:0] b [5] = '{TRIG_BAR, TRIG_BAR, TRIG_BAR, TRIG_BAR, BAR_MEM64};
    logic [3:0] e [5] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'h0};
    logic [3:0] seen;
    int busy;
    for (int i = 0; i < 5; i++) begin
      seen = 4'h0;
      busy = 0;
      u_core.send(REQ_MEM_WR, b[i], a[i], 11'h1, 8'h60, v[i]);
      repeat (4) begin
        @(posedge ref_clk);
        #1;
        seen = seen | trig;
        busy += int'(wr_busy === 1'b1);
      end
      check("trigger pulses", {28'h0, e[i]}, {28'h0, seen});
      check("write busy cycles", 32'h1, busy);
    end
    $display("done triggers");
  endtask

  // clock enable dropped while a read completion is being built
  task automatic t_freeze();
    u_core.send(REQ_MEM_RD, BAR_MEM32, 62'h7, 11'h1, 8'h70, 32'h0);
    @(negedge ref_clk);
    ce = 1'b0;
    repeat (6) @(negedge ref_clk);
    check("frozen accept", 32'h0, {31'h0, accept});
    check("frozen completion", 32'h0, {31'h0, cc_tvalid});
    check("frozen queue", 32'h0, u_core.cpl_q.size());
    ce = 1'b1;
    expect_cpl(8'h70, 62'h7, 32'hc0de_0000, 1'b0, 1'b0);
    $display("done freeze");
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // roughly forty times the expected run
  initial begin
    #20000;
    n_errors++;
    complete_run();
  end

  initial begin
    n_errors = 0;
    checked = 0;
    rstn = 1'b0;
    ce = 1'b1;
    slow = 1'b0;
    repeat (3) @(negedge ref_clk);
    rstn = 1'b1;
    t_regions();
    t_wrap();
    t_backpressure();
    t_refused();
    t_triggers();
    t_freeze();
    complete_run();
  end
endmodule
